// ===== design/pcm_port_defs.svh
// Register offsets, field positions, reset values and counts of the voice serial port
`ifndef PCM_PORT_DEFS_SVH
`define PCM_PORT_DEFS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define CFG_ADDR        8'h00
`define TIM_ADDR        8'h04
`define STAT_ADDR       8'h08

// ----------------------------------------
// Configuration word fields
// ----------------------------------------
`define CFG_EN_BIT      0
`define CFG_MASTER_BIT  1
`define CFG_FRAME_LSB   2
`define CFG_SAMPLE_LSB  4
`define CFG_SLOT16_BIT  6
`define CFG_SLOTS_LSB   7
`define CFG_FILL_LSB    11
`define CFG_ATTEN_LSB   13
`define CFG_BIGEND_BIT  16
`define CFG_TRIFALL_BIT 17
`define CFG_RESET       32'h0001_00C0
`define CFG_MASK        32'h0003_FFFF

// ----------------------------------------
// Timing word fields
// ----------------------------------------
`define TIM_DIV_LSB     0
`define TIM_FLEN_LSB    8
`define TIM_RESET       32'h0000_4027
`define TIM_MASK        32'h0001_FFFF

// ----------------------------------------
// Frame geometry
// ----------------------------------------
`define LONG_SYNC_BITS  9'h008
`define SPAN_SLOT16     7'h40
`define SPAN_SLOT8      7'h20
`define SLOT16_LAST     4'hF
`define SLOT8_LAST      4'h7
`define GCI_SLOT_MASK   4'h3
`define MAX_CHANNELS    3

`endif

// ===== design/pcm_port_pkg.sv
// Types of the voice serial port
package pcm_port_pkg;

	typedef enum logic [1:0] {
		FRAME_LONG  = 2'b00,
		FRAME_SHORT = 2'b01,
		FRAME_GCI   = 2'b10
	} frame_fmt_e;

	typedef enum logic [1:0] {
		SAMPLE_LIN13 = 2'b00,
		SAMPLE_LIN16 = 2'b01,
		SAMPLE_ULAW  = 2'b10,
		SAMPLE_ALAW  = 2'b11
	} sample_fmt_e;

	typedef enum logic [1:0] {
		FILL_SIGN  = 2'b00,
		FILL_ZERO  = 2'b01,
		FILL_ATTEN = 2'b10
	} fill_e;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_HUNT = 2'b01,
		ST_RUN  = 2'b10
	} port_state_e;

endpackage : pcm_port_pkg

// ===== design/tx_sample_mem.sv
// Transmit sample store, one word per slot, registered read
`timescale 1ns/1ps
module tx_sample_mem (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        wr_en,
	input  wire logic [1:0]  wr_addr,
	input  wire logic [15:0] wr_data,
	input  wire logic [1:0]  rd_addr,
	output logic      [15:0] rd_data
);
	logic [15:0] mem [0:3];
	logic [15:0] rd_q;

	// ----------------------------------------
	// Storage
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rd_q <= 16'h0000;
		end else begin
			rd_q <= mem[rd_addr];
		end
	end

	assign rd_data = rd_q;
endmodule : tx_sample_mem

// ===== design/pcm_voice_serial_port.sv
// Voice serial port: APB configuration, bit clock and frame sync, slot serialiser
`timescale 1ns/1ps
`include "pcm_port_defs.svh"

// Functional notes
// - As master the port drives bit clock and frame sync itself.
// - As slave both clock and sync come from the far party.
// - Long frame sync: sync rising edge starts the sample word.
// - Long sync master holds sync high exactly eight bit clocks.
// - Input sampled on falling bit clock edge, output launched on rising.
// - Output release after last bit: on its falling edge or next rising.
// - Short frame sync: sync falling edge starts the sample word.
// - Short frame sync pulse lasts exactly one bit clock.
// - At most three voice channels in any of the first four slots.
// - Samples are 13-bit or 16-bit linear, or 8-bit mu-law or A-law.
// - GCI mode carries the two B channels in consecutive slots.
// - GCI frames start on sync rising edge and repeat at 8 kHz.
// - Samples stream directly to voice hardware, no host protocol involved.
// - Long, short and GCI framing are selected by configuration.
// - Slots are 8 or 16 bit clocks; 8 only for 8-bit samples (GCI here always uses 8, linear samples too).
// - Spare bits of 16-clock slots: sign, zeros or 3-bit attenuation.
// - Bit order within a sample is little or big endian.
module pcm_voice_serial_port (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        bclk_in,
	output logic             bclk_out,
	output logic             bclk_oe,
	input  wire logic        sync_in,
	output logic             sync_out,
	output logic             sync_oe,
	input  wire logic        sdata_in,
	output logic             sdata_out,
	output logic             sdata_oe,
	input  wire logic        tx_wr_en,
	input  wire logic [1:0]  tx_wr_slot,
	input  wire logic [15:0] tx_wr_data,
	output logic      [15:0] rx_sample,
	output logic      [1:0]  rx_slot,
	output logic             rx_valid
);
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [1:0] reg_sel(input logic [7:0] a);
		logic [1:0] r;
		r = 2'h3;
		if (a == `CFG_ADDR) r = 2'h0;
		if (a == `TIM_ADDR) r = 2'h1;
		if (a == `STAT_ADDR) r = 2'h2;
		return r;
	endfunction : reg_sel

	function automatic logic [3:0] limit3(input logic [3:0] m);
		logic [3:0] r;
		int         n;
		r = 4'h0;
		n = 0;
		for (int i = 0; i < 4; i++) begin
			if (m[i] && n < `MAX_CHANNELS) begin
				r[i] = 1'h1;
				n++;
			end
		end
		return r;
	endfunction : limit3

	function automatic logic [1:0] slot_of(input logic [6:0] p, input logic s16);
		return s16 ? p[5:4] : p[4:3];
	endfunction : slot_of

	function automatic logic [3:0] bit_of(input logic [6:0] p, input logic s16);
		return s16 ? p[3:0] : {1'h0, p[2:0]};
	endfunction : bit_of

	function automatic logic [15:0] fmt_word(input logic [15:0] s,
		input pcm_port_pkg::sample_fmt_e sf, input pcm_port_pkg::fill_e fl,
		input logic [2:0] att, input logic s16);
		logic [15:0] w;
		w = s;
		if (sf == pcm_port_pkg::SAMPLE_LIN13) begin
			w = (fl == pcm_port_pkg::FILL_SIGN) ? {{3{s[12]}}, s[12:0]} :
				(fl == pcm_port_pkg::FILL_ATTEN) ? {s[12:0], att} : {s[12:0], 3'h0};
		end else if (sf != pcm_port_pkg::SAMPLE_LIN16) begin
			w = !s16 ? {8'h00, s[7:0]} :
				(fl == pcm_port_pkg::FILL_SIGN) ? {{8{s[7]}}, s[7:0]} :
				(fl == pcm_port_pkg::FILL_ATTEN) ? {s[7:0], att, 5'h00} : {s[7:0], 8'h00};
		end
		return w;
	endfunction : fmt_word

	function automatic logic tx_bit(input logic [15:0] w, input logic [3:0] idx,
		input logic s16, input logic be);
		logic [3:0] msb;
		msb = s16 ? `SLOT16_LAST : `SLOT8_LAST;
		return be ? w[msb - idx] : w[idx];
	endfunction : tx_bit

	function automatic logic [15:0] rx_norm(input logic [15:0] sh, input logic s16,
		input logic be);
		logic [15:0] r;
		r = 16'h0000;
		for (int i = 0; i < 16; i++) begin
			r[i] = sh[15 - i];
		end
		if (be) return s16 ? sh : {8'h00, sh[7:0]};
		return s16 ? r : {8'h00, r[15:8]};
	endfunction : rx_norm

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	logic [31:0]                 cfg_q, cfg_d, tim_q, tim_d, prdata_q, prdata_d;
	logic                        pready_q, pready_d, pslverr_q, pslverr_d;
	logic [2:0]                  bclk_sq, sync_sq;
	logic [1:0]                  din_sq;
	logic [7:0]                  div_q, div_d;
	logic                        bclk_q, bclk_d, msync_q, msync_d, drv_q, drv_d;
	logic [8:0]                  fcnt_q, fcnt_d, fcnt_wrap, flen_m1;
	pcm_port_pkg::port_state_e   st_q, st_d, lst;
	logic [6:0]                  pos_q, pos_d, lp;
	logic [15:0]                 word_q, word_d, lw, rxsh_q, rxsh_d, rxs_q, rxs_d;
	logic [15:0]                 frames_q, frames_d, rd_data;
	logic                        dout_q, dout_d, doe_q, doe_d, last_q, last_d;
	logic                        arm_q, arm_d, rxv_q, rxv_d, syncp_q, syncp_d, act;
	logic [1:0]                  rxslot_q, rxslot_d, curslot_q, curslot_d;
	logic                        en, master, gci, slot16, big_end, sync_lvl;
	logic                        rise_ev, fall_ev, start_ev;
	logic [3:0]                  slot_mask;
	pcm_port_pkg::frame_fmt_e    ffmt;
	pcm_port_pkg::sample_fmt_e   sfmt;

	// ----------------------------------------
	// Configuration decode
	// ----------------------------------------
	assign en      = cfg_q[`CFG_EN_BIT];
	assign master  = cfg_q[`CFG_MASTER_BIT];
	assign big_end = cfg_q[`CFG_BIGEND_BIT];
	assign ffmt    = pcm_port_pkg::frame_fmt_e'(cfg_q[`CFG_FRAME_LSB +: 2]);
	assign sfmt    = pcm_port_pkg::sample_fmt_e'(cfg_q[`CFG_SAMPLE_LSB +: 2]);
	assign gci     = (ffmt == pcm_port_pkg::FRAME_GCI);
	assign slot16  = !gci && (cfg_q[`CFG_SLOT16_BIT] || sfmt == pcm_port_pkg::SAMPLE_LIN13 ||
		sfmt == pcm_port_pkg::SAMPLE_LIN16);
	assign slot_mask = gci ? `GCI_SLOT_MASK : limit3(cfg_q[`CFG_SLOTS_LSB +: 4]);

	// ----------------------------------------
	// APB slave
	// ----------------------------------------
	always_comb begin
		cfg_d     = cfg_q;
		tim_d     = tim_q;
		prdata_d  = prdata_q;
		pready_d  = 1'h0;
		pslverr_d = 1'h0;
		if (psel && !penable) begin
			pready_d  = 1'h1;
			pslverr_d = (reg_sel(paddr) == 2'h3);
			prdata_d  = 32'h0000_0000;
			if (reg_sel(paddr) == 2'h0) prdata_d = cfg_q;
			if (reg_sel(paddr) == 2'h1) prdata_d = tim_q;
			if (reg_sel(paddr) == 2'h2) prdata_d = {frames_q, 12'h000, st_q, 1'h0, drv_q};
		end
		if (psel && penable && pready_q && pwrite) begin
			if (reg_sel(paddr) == 2'h0 && (!en || !pwdata[`CFG_EN_BIT])) cfg_d = pwdata & `CFG_MASK;
			if (reg_sel(paddr) == 2'h1 && !en) tim_d = pwdata & `TIM_MASK;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cfg_q     <= `CFG_RESET;
			tim_q     <= `TIM_RESET;
			prdata_q  <= 32'h0000_0000;
			pready_q  <= 1'h0;
			pslverr_q <= 1'h0;
		end else begin
			cfg_q     <= cfg_d;
			tim_q     <= tim_d;
			prdata_q  <= prdata_d;
			pready_q  <= pready_d;
			pslverr_q <= pslverr_d;
		end
	end

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bclk_sq <= 3'h0;
			sync_sq <= 3'h0;
			din_sq  <= 2'h0;
		end else begin
			bclk_sq <= {bclk_sq[1:0], bclk_in};
			sync_sq <= {sync_sq[1:0], sync_in};
			din_sq  <= {din_sq[0], sdata_in};
		end
	end

	assign rise_ev  = master ? (div_q == 8'h00 && !bclk_q) : (bclk_sq[1] && !bclk_sq[2]);
	assign fall_ev  = master ? (div_q == 8'h00 && bclk_q) : (!bclk_sq[1] && bclk_sq[2]);
	assign sync_lvl = sync_sq[1];

	// ----------------------------------------
	// Master bit clock and frame sync
	// ----------------------------------------
	assign flen_m1   = tim_q[`TIM_FLEN_LSB +: 9] - 9'h001;
	assign fcnt_wrap = (fcnt_q == flen_m1) ? 9'h000 : fcnt_q + 9'h001;

	always_comb begin
		div_d   = div_q;
		bclk_d  = bclk_q;
		fcnt_d  = fcnt_q;
		msync_d = msync_q;
		drv_d   = en && master;
		if (en && master) begin
			if (div_q == 8'h00) begin
				div_d  = tim_q[`TIM_DIV_LSB +: 8];
				bclk_d = !bclk_q;
			end else begin
				div_d = div_q - 8'h01;
			end
			if (rise_ev) begin
				fcnt_d = fcnt_wrap;
				msync_d = (ffmt == pcm_port_pkg::FRAME_SHORT) ? (fcnt_wrap == flen_m1) :
					(fcnt_wrap < `LONG_SYNC_BITS);
			end
		end else begin
			div_d   = 8'h00;
			bclk_d  = 1'h0;
			fcnt_d  = flen_m1;
			msync_d = 1'h0;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			div_q   <= 8'h00;
			bclk_q  <= 1'h0;
			fcnt_q  <= 9'h000;
			msync_q <= 1'h0;
			drv_q   <= 1'h0;
		end else begin
			div_q   <= div_d;
			bclk_q  <= bclk_d;
			fcnt_q  <= fcnt_d;
			msync_q <= msync_d;
			drv_q   <= drv_d;
		end
	end

	// ----------------------------------------
	// Frame start detection
	// ----------------------------------------
	// start edges
	assign start_ev = rise_ev && (master ? (fcnt_wrap == 9'h000) :
		(ffmt == pcm_port_pkg::FRAME_SHORT) ? (!sync_lvl && syncp_q) : (sync_lvl && !syncp_q));

	// ----------------------------------------
	// Slot serialiser and receiver
	// ----------------------------------------
	// direct sample path
	tx_sample_mem u_mem (
		.clk     (clk),
		.rst     (rst),
		.wr_en   (tx_wr_en),
		.wr_addr (tx_wr_slot),
		.wr_data (tx_wr_data),
		.rd_addr (slot_of(pos_q, slot16)),
		.rd_data (rd_data)
	);

	always_comb begin
		st_d      = st_q;
		pos_d     = pos_q;
		word_d    = word_q;
		dout_d    = dout_q;
		doe_d     = doe_q;
		last_d    = last_q;
		arm_d     = arm_q;
		rxsh_d    = rxsh_q;
		rxs_d     = rxs_q;
		rxslot_d  = rxslot_q;
		rxv_d     = 1'h0;
		frames_d  = frames_q;
		syncp_d   = syncp_q;
		curslot_d = curslot_q;
		lp        = pos_q;
		lw        = word_q;
		act       = 1'h0;
		lst       = st_q;
		if (!en) begin
			st_d   = pcm_port_pkg::ST_IDLE;
			pos_d  = 7'h00;
			doe_d  = 1'h0;
			arm_d  = 1'h0;
			last_d = 1'h0;
			syncp_d = 1'h0;
		end else begin
			if (rise_ev) begin
				syncp_d = sync_lvl;
				if (start_ev) begin
					lst      = pcm_port_pkg::ST_RUN;
					lp       = 7'h00;
					frames_d = frames_q + 16'h0001;
				end
				unique case (lst)
					pcm_port_pkg::ST_IDLE, pcm_port_pkg::ST_HUNT: begin
						st_d  = pcm_port_pkg::ST_HUNT;
						doe_d = 1'h0;
						arm_d = 1'h0;
					end
					pcm_port_pkg::ST_RUN: begin
						if (lp < (slot16 ? `SPAN_SLOT16 : `SPAN_SLOT8)) begin
							st_d = pcm_port_pkg::ST_RUN;
							if (bit_of(lp, slot16) == 4'h0) begin
								lw = fmt_word(rd_data, sfmt,
									pcm_port_pkg::fill_e'(cfg_q[`CFG_FILL_LSB +: 2]),
									cfg_q[`CFG_ATTEN_LSB +: 3], slot16);
							end
							act       = slot_mask[slot_of(lp, slot16)];
							word_d    = lw;
							dout_d    = act ? tx_bit(lw, bit_of(lp, slot16), slot16, big_end) : 1'h0;
							doe_d     = act;
							arm_d     = act;
							last_d    = bit_of(lp, slot16) == (slot16 ? `SLOT16_LAST : `SLOT8_LAST);
							curslot_d = slot_of(lp, slot16);
							pos_d     = lp + 7'h01;
						end else begin
							st_d   = pcm_port_pkg::ST_HUNT;
							pos_d  = 7'h00;
							doe_d  = 1'h0;
							arm_d  = 1'h0;
							last_d = 1'h0;
						end
					end
					default: st_d = pcm_port_pkg::ST_IDLE;
				endcase
			end
			if (fall_ev) begin
				if (arm_q) begin
					rxsh_d = {rxsh_q[14:0], din_sq[1]};
					if (last_q) begin
						rxs_d    = rx_norm({rxsh_q[14:0], din_sq[1]}, slot16, big_end);
						rxslot_d = curslot_q;
						rxv_d    = 1'h1;
						arm_d    = 1'h0;
					end
				end
				if (cfg_q[`CFG_TRIFALL_BIT] && last_q) doe_d = 1'h0;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_q      <= pcm_port_pkg::ST_IDLE;
			pos_q     <= 7'h00;
			word_q    <= 16'h0000;
			dout_q    <= 1'h0;
			doe_q     <= 1'h0;
			last_q    <= 1'h0;
			arm_q     <= 1'h0;
			rxsh_q    <= 16'h0000;
			rxs_q     <= 16'h0000;
			rxslot_q  <= 2'h0;
			rxv_q     <= 1'h0;
			frames_q  <= 16'h0000;
			syncp_q   <= 1'h0;
			curslot_q <= 2'h0;
		end else begin
			st_q      <= st_d;
			pos_q     <= pos_d;
			word_q    <= word_d;
			dout_q    <= dout_d;
			doe_q     <= doe_d;
			last_q    <= last_d;
			arm_q     <= arm_d;
			rxsh_q    <= rxsh_d;
			rxs_q     <= rxs_d;
			rxslot_q  <= rxslot_d;
			rxv_q     <= rxv_d;
			frames_q  <= frames_d;
			syncp_q   <= syncp_d;
			curslot_q <= curslot_d;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign prdata    = prdata_q;
	assign pready    = pready_q;
	assign pslverr   = pslverr_q;
	assign bclk_out  = bclk_q;
	assign bclk_oe   = drv_q;
	assign sync_out  = msync_q;
	assign sync_oe   = drv_q;
	assign sdata_out = dout_q;
	assign sdata_oe  = doe_q;
	assign rx_sample = rxs_q;
	assign rx_slot   = rxslot_q;
	assign rx_valid  = rxv_q;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	logic [3:0] hcnt_q;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			hcnt_q <= 4'h0;
		end else begin
			hcnt_q <= !msync_q ? 4'h0 : (rise_ev ? hcnt_q + 4'h1 : hcnt_q);
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	a_master_drives: assert property ((en && master) [*2] |-> bclk_oe && sync_oe)
		else $error("master does not drive clock and sync");
	a_slave_listens: assert property (!master |=> !bclk_oe && !sync_oe)
		else $error("slave drives clock or sync");
	a_long_width: assert property ($fell(msync_q) && en && ffmt == pcm_port_pkg::FRAME_LONG |->
		hcnt_q == 4'h8)
		else $error("long sync not eight bit clocks");
	a_short_width: assert property ($fell(msync_q) && en && ffmt == pcm_port_pkg::FRAME_SHORT |->
		hcnt_q == 4'h1)
		else $error("short sync not one bit clock");
	a_launch_rise: assert property ($changed(sdata_out) |-> $past(rise_ev))
		else $error("output changed off a rising edge");
	a_sample_fall: assert property ($changed(rxsh_q) |-> $past(fall_ev))
		else $error("input sampled off a falling edge");
	a_release_edge: assert property ($fell(sdata_oe) |-> $past(rise_ev || fall_ev || !en))
		else $error("output released off a bit clock edge");
	a_channel_limit: assert property ($countones(slot_mask) <= 3)
		else $error("more than three channels enabled");
	a_config_stable: assert property (en && $past(en) |-> $stable(cfg_q[17:1]))
		else $error("configuration changed while running");
	a_idle_hiz: assert property (st_q != pcm_port_pkg::ST_RUN |-> !sdata_oe)
		else $error("output driven outside a frame");

endmodule : pcm_voice_serial_port

// ===== testbench/voice_codec.sv
// Behavioural far-side codec that clocks the port as its slave
`timescale 1ns/1ps
module voice_codec (
	input  wire logic       [1:0] fmt,
	input  wire logic       [7:0] tx_byte,
	input  wire logic      [31:0] quota,
	input  wire logic             pin_out,
	input  wire logic             pin_oe,
	output logic                  bclk,
	output logic                  sync,
	output logic                  sdat,
	output logic            [7:0] got,
	output logic                  oe_mid,
	output logic                  oe_after,
	output int                    frames
);
	int r;

	// ----------------------------------------
	// Frame generator, clock still once the frame quota is reached
	// ----------------------------------------
	initial begin
		bclk = 1'b0;
		sync = 1'b0;
		sdat = 1'b0;
		got = 8'h00;
		oe_mid = 1'b0;
		oe_after = 1'b0;
		frames = 0;
		forever begin
			wait (frames < quota);
			// Keep link edges off the system clock edges
			#5;
			for (r = 0; r < 33; r++) begin
				// sync from this side, width per format
				sync = (fmt == pcm_port_pkg::FRAME_SHORT) ? (r == 0) : (r >= 1 && r <= 8);
				#100 bclk = 1'b1;
				if (r == 9) oe_mid = pin_oe;
				#50 sdat = (r >= 1 && r <= 8) ? tx_byte[8 - r] : ~sdat;
				#50 bclk = 1'b0;
				// Output pin has a pull-down when released
				if (r >= 1 && r <= 8) got[8 - r] = pin_oe & pin_out;
				if (r == 9) oe_after = pin_oe;
			end
			sync = 1'b0;
			frames++;
		end
	end
endmodule : voice_codec

// ===== testbench/tb_pcm_voice_serial_port.sv
// Self-checking testbench of the voice serial port
`timescale 1ns/1ps
`include "pcm_port_defs.svh"
module tb_pcm_voice_serial_port;
	logic        clk        = 1'b0;
	logic        rst        = 1'b1;
	logic [7:0]  paddr      = 8'h00;
	logic        psel       = 1'b0;
	logic        penable    = 1'b0;
	logic        pwrite     = 1'b0;
	logic [31:0] pwdata     = 32'h0;
	logic        tx_wr_en   = 1'b0;
	logic [1:0]  tx_wr_slot = 2'h0;
	logic [15:0] tx_wr_data = 16'h0;
	logic [1:0]  fmt        = 2'h0;
	logic [7:0]  tx_byte    = 8'h00;
	int          quota      = 0;
	logic [31:0] prdata, rd, v, seed;
	logic        pready, pslverr, er, pb;
	logic        bclk_out, bclk_oe, sync_out, sync_oe, sdata_out, sdata_oe;
	logic        m_bclk, m_sync, m_sdat, oe_mid, oe_after, rx_valid;
	logic [15:0] rx_sample, rx_last;
	logic [1:0]  rx_slot;
	logic [7:0]  got;
	wire         bclk_pin, sync_pin;
	int          frames, checks, n_mismatch, cyc, i, n;

	assign bclk_pin = bclk_oe ? bclk_out : m_bclk;
	assign sync_pin = sync_oe ? sync_out : m_sync;

	pcm_voice_serial_port dut (.clk(clk), .rst(rst), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .bclk_in(bclk_pin), .bclk_out(bclk_out),
		.bclk_oe(bclk_oe), .sync_in(sync_pin), .sync_out(sync_out), .sync_oe(sync_oe),
		.sdata_in(m_sdat), .sdata_out(sdata_out), .sdata_oe(sdata_oe),
		.tx_wr_en(tx_wr_en), .tx_wr_slot(tx_wr_slot), .tx_wr_data(tx_wr_data),
		.rx_sample(rx_sample), .rx_slot(rx_slot), .rx_valid(rx_valid));

	voice_codec codec (.fmt(fmt), .tx_byte(tx_byte), .quota(quota), .pin_out(sdata_out),
		.pin_oe(sdata_oe), .bclk(m_bclk), .sync(m_sync), .sdat(m_sdat), .got(got),
		.oe_mid(oe_mid), .oe_after(oe_after), .frames(frames));

	// ----------------------------------------
	// Clock, timeout, received word
	// ----------------------------------------
	initial begin
		forever #12.5 clk = ~clk;
	end

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_mismatch++;
			finish_test();
		end
		if (rx_valid === 1'b1 && rx_slot === 2'h0) rx_last <= rx_sample;
	end

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd

	function automatic logic [31:0] cfg_word(input logic [1:0] fr, input logic ms,
		input logic tf, input logic be);
		return 32'h1 | (32'(ms) << `CFG_MASTER_BIT) | (32'(fr) << `CFG_FRAME_LSB)
			| (32'h2 << `CFG_SAMPLE_LSB) | (32'h1 << `CFG_SLOTS_LSB)
			| (32'(be) << `CFG_BIGEND_BIT) | (32'(tf) << `CFG_TRIFALL_BIT);
	endfunction : cfg_word

	// Codec sends and takes MSB first; little endian mirrors the byte
	function automatic logic [31:0] exp_rx(input logic [7:0] b, input logic be);
		logic [7:0] r;
		for (int j = 0; j < 8; j++) r[j] = b[7 - j];
		return {24'h0, be ? b : r};
	endfunction : exp_rx

	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rdv, output logic erv);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rdv = prdata;
		erv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task finish_test();
		$display("checks %0d n_mismatch %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : finish_test

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		seed = 32'h6;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		apb(1'b0, `CFG_ADDR, 32'h0, rd, er);
		chk("cfg_reset", rd, `CFG_RESET);
		apb(1'b0, `TIM_ADDR, 32'h0, rd, er);
		chk("tim_reset", rd, `TIM_RESET);
		for (i = 0; i < 3; i++) begin
			v = rnd();
			apb(1'b1, 8'h0C + {2'b00, v[3:0], 2'b00}, v, rd, er);
			chk("unmapped_err", {31'h0, er}, 32'h1);
			apb(1'b0, 8'h0C + {2'b00, v[3:0], 2'b00}, 32'h0, rd, er);
			chk("unmapped_rd", rd, 32'h0);
		end
		for (i = 0; i < 3; i++) begin
			v = rnd();
			tx_byte <= v[7:0];
			fmt <= 2'(i);
			apb(1'b1, `CFG_ADDR, 32'h0, rd, er);
			apb(1'b1, `CFG_ADDR, cfg_word(2'(i), 1'b0, i[0], !i[0]), rd, er);
			@(posedge clk);
			tx_wr_en <= 1'b1;
			tx_wr_slot <= 2'h0;
			tx_wr_data <= {8'h00, v[7:0]};
			@(posedge clk);
			tx_wr_slot <= 2'h1;
			@(posedge clk);
			tx_wr_en <= 1'b0;
			quota <= quota + 2;
			do begin
				@(posedge clk);
			end while (frames < quota);
			chk("slave_no_drive", {30'h0, bclk_oe, sync_oe}, 32'h0);
			chk("tx_bits", {24'h0, got}, exp_rx(v[7:0], !i[0]));
			chk("rx_word", {16'h0, rx_last}, exp_rx(v[7:0], !i[0]));
			chk("oe_release", {31'h0, oe_after}, {31'h0, i == 2});
			chk("oe_fall", {31'h0, oe_mid}, {31'h0, !i[0]});
		end
		apb(1'b1, `CFG_ADDR, 32'h0, rd, er);
		apb(1'b1, `TIM_ADDR, 32'h0000_2003, rd, er);
		apb(1'b1, `CFG_ADDR, cfg_word(2'b00, 1'b1, 1'b0, 1'b1), rd, er);
		apb(1'b1, `TIM_ADDR, `TIM_RESET, rd, er);
		apb(1'b0, `TIM_ADDR, 32'h0, rd, er);
		chk("tim_locked", rd, 32'h0000_2003);
		while (sync_out !== 1'b0) begin
			@(posedge clk);
			#1;
		end
		while (sync_out !== 1'b1) begin
			@(posedge clk);
			#1;
		end
		// Count bit clock rises up to the one that ends the sync
		pb = bclk_out;
		n = 0;
		while (sync_out === 1'b1) begin
			@(posedge clk);
			#1;
			if (bclk_out === 1'b1 && pb === 1'b0) n++;
			pb = bclk_out;
		end
		chk("sync_width", 32'(n), 32'h8);
		chk("master_drive", {30'h0, bclk_oe, sync_oe}, 32'h3);
		finish_test();
	end
endmodule : tb_pcm_voice_serial_port
